// ==== isb_map.svh ====
`ifndef ISB_MAP_SVH
`define ISB_MAP_SVH
// Wishbone byte offsets
`define ISB_WB_CFG_A        8'h00
`define ISB_WB_MODE         8'h04
`define ISB_WB_STATUS       8'h08
`define ISB_IO_BASE_RST     10'h300
`define ISB_MODE_RST        2'h0
// ISA I/O window offsets within the 32-byte block
`define ISB_IO_SMEM_ADDR    5'h00
`define ISB_IO_WIDTH_DET    5'h01
`define ISB_IO_WIN_LO       5
`define ISB_IO_WIN_HI       9
// Shared-memory window compare fields
`define ISB_SMEM_CMP_COMPAT 14
`define ISB_SMEM_CMP_ENH    16
`define ISB_SMEM_REG_LSB    12
`define ISB_SA_MSB          19
`define ISB_COMPAT_OFF_MSB  13
`define ISB_FIFO_DEPTH      4
`define ISB_FIFO_PW         2
`endif

// ==== isb_pkg.sv ====
package isb_pkg;
  // Bus interface modes
  typedef enum logic [1:0] {
    ISB_SMEM_COMPAT = 2'b00,
    ISB_SMEM_ENH    = 2'b01,
    ISB_IOP_COMPAT  = 2'b10,
    ISB_IOP_ENH     = 2'b11
  } isb_mode_t;

  // Host memory cycle states
  typedef enum logic [1:0] {
    ISB_H_IDLE = 2'b00,
    ISB_H_WAIT = 2'b01,
    ISB_H_DATA = 2'b10,
    ISB_H_HOLD = 2'b11
  } isb_hstate_t;

  // Core buffer request
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } isb_core_req_t;
endpackage

// ==== isb_fifo.sv ====
`include "isb_map.svh"
module isb_fifo
  import isb_pkg::*;
(
  input  wire logic          core_clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic          in_valid_i,
  output logic               in_ready_o,
  input  isb_core_req_t      in_data_i,
  output logic               out_valid_o,
  input  wire logic          out_ready_i,
  output isb_core_req_t      out_data_o
);
  isb_core_req_t            mem [`ISB_FIFO_DEPTH];
  logic [`ISB_FIFO_PW-1:0]  wr_ptr;
  logic [`ISB_FIFO_PW-1:0]  rd_ptr;
  logic [`ISB_FIFO_PW:0]    count;
  logic                     push;
  logic                     pop;

  // Honest full and empty from the fill count
  assign in_ready_o  = (count != (`ISB_FIFO_PW+1)'(`ISB_FIFO_DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Storage, no reset needed on data
  always_ff @(posedge core_clk_i) begin
    if (ce_i && push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers and count
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (ce_i) begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end
endmodule // isb_fifo

// ==== isb_top.sv ====
// Design decisions made here: the register offsets and the Wishbone register port.
`include "isb_map.svh"
module isb_top
  import isb_pkg::*;
(
  input  wire logic          core_clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic          data_width_select_i,
  // Wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic [31:0]        wb_dat_o,
  output logic               wb_ack_o,
  // ISA host bus
  input  wire logic [19:0]   isa_sa_i,
  input  wire logic          isa_memr_n_i,
  input  wire logic          isa_memw_n_i,
  input  wire logic          isa_ior_n_i,
  input  wire logic          isa_iow_n_i,
  input  wire logic [15:0]   isa_sd_i,
  output logic [15:0]        isa_sd_o,
  output logic               isa_sd_oe_o,
  output logic               isa_chrdy_o,
  output logic               isa_chrdy_oe_o,
  // Controller core buffer port
  input  wire logic          core_valid_i,
  input  isb_core_req_t      core_req_i,
  output logic               core_ready_o,
  output logic [15:0]        core_rdata_o,
  output logic               core_rvalid_o,
  // External packet buffer RAM
  output logic [14:0]        ram_addr_o,
  output logic               ram_we_o,
  output logic               ram_cs_lo_o,
  output logic               ram_cs_hi_o,
  output logic [15:0]        ram_wdata_o,
  input  wire logic [15:0]   ram_rdata_i
);
  logic                 width16;
  logic                 strap_taken;
  logic [9:0]           io_base;
  isb_mode_t            mode;
  logic [7:0]           smem_addr;
  logic                 smem_valid;
  isb_hstate_t          hstate;
  isb_hstate_t          next_hstate;
  logic                 iow_seen;
  logic                 ior_seen;
  logic                 core_rd_pend;
  isb_core_req_t        fifo_out;
  logic                 fifo_valid;
  logic                 core_issue;
  logic                 host_issue;
  logic                 mem_mode;
  logic                 smem_hit;
  logic                 mem_sel;
  logic                 io_hit;
  logic [4:0]           io_off;
  logic [15:0]          host_off;
  logic [14:0]          host_ram_addr;
  logic [14:0]          core_ram_addr;
  logic [15:0]          host_wdata;
  logic [15:0]          core_wdata;
  logic [7:0]           io_rd_val;
  logic                 wb_req;
  logic [31:0]          wb_rd_val;

  // Width strap caught once after reset release, then frozen
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      width16     <= 1'b0;
      strap_taken <= 1'b0;
    end else if (ce_i && !strap_taken) begin
      width16     <= data_width_select_i; // High in 16-bit slot
      strap_taken <= 1'b1;                // Pulled-down pin reads low
    end
  end

  // Core requests queue ahead of the RAM so host stalls do not drop them
  isb_fifo u_core_fifo (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_valid_i  (core_valid_i),
    .in_ready_o  (core_ready_o),
    .in_data_i   (core_req_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (1'b1),
    .out_data_o  (fifo_out)
  );

  // Mode decode: memory window only in the shared-memory modes
  assign mem_mode = (mode == ISB_SMEM_COMPAT) || (mode == ISB_SMEM_ENH);

  // Window compare: compat maps 16 KB, enhanced maps 64 KB
  always_comb begin
    if (mode == ISB_SMEM_COMPAT) begin
      smem_hit = isa_sa_i[`ISB_SA_MSB:`ISB_SMEM_CMP_COMPAT] ==
                 smem_addr[7:`ISB_SMEM_CMP_COMPAT-`ISB_SMEM_REG_LSB];
      host_off = {2'b00, isa_sa_i[`ISB_COMPAT_OFF_MSB:0]};
    end else begin
      smem_hit = isa_sa_i[`ISB_SA_MSB:`ISB_SMEM_CMP_ENH] ==
                 smem_addr[7:`ISB_SMEM_CMP_ENH-`ISB_SMEM_REG_LSB];
      host_off = isa_sa_i[15:0];
    end
  end

  // Buffer decoded only once its address register has been written
  assign mem_sel = mem_mode && smem_valid && strap_taken && smem_hit &&
                   (!isa_memr_n_i || !isa_memw_n_i);

  // Registers live in I/O space at the configured base
  assign io_hit = isa_sa_i[`ISB_IO_WIN_HI:`ISB_IO_WIN_LO] ==
                  io_base[`ISB_IO_WIN_HI:`ISB_IO_WIN_LO];
  assign io_off = isa_sa_i[`ISB_IO_WIN_LO-1:0];

  // Word addressing in 16-bit mode, byte addressing in 8-bit mode
  assign host_ram_addr = width16 ? host_off[15:1] : host_off[14:0];
  assign core_ram_addr = width16 ? fifo_out.addr[15:1] : fifo_out.addr[14:0];
  assign host_wdata    = width16 ? isa_sd_i : {8'h00, isa_sd_i[7:0]};
  assign core_wdata    = width16 ? fifo_out.wdata : {8'h00, fifo_out.wdata[7:0]};

  // Core always wins the RAM; host only when the queue is empty
  assign core_issue = fifo_valid;
  assign host_issue = (hstate == ISB_H_WAIT) && !fifo_valid;

  // One RAM access per cycle, registered outputs
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ram_addr_o  <= '0;
      ram_we_o    <= 1'b0;
      ram_cs_lo_o <= 1'b0;
      ram_cs_hi_o <= 1'b0;
      ram_wdata_o <= '0;
    end else if (ce_i) begin
      ram_we_o    <= 1'b0;
      ram_cs_lo_o <= 1'b0;
      ram_cs_hi_o <= 1'b0;
      if (core_issue) begin
        ram_addr_o  <= core_ram_addr;
        ram_we_o    <= fifo_out.we;
        ram_cs_lo_o <= 1'b1;
        ram_cs_hi_o <= width16; // Upper RAM only in 16-bit mode
        ram_wdata_o <= core_wdata;
      end else if (host_issue) begin
        ram_addr_o  <= host_ram_addr;
        ram_we_o    <= !isa_memw_n_i;
        ram_cs_lo_o <= 1'b1;
        ram_cs_hi_o <= width16;
        ram_wdata_o <= host_wdata;
      end
    end
  end

  // Core read data returns the cycle after the RAM strobe
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      core_rd_pend  <= 1'b0;
      core_rdata_o  <= '0;
      core_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      core_rd_pend  <= core_issue && !fifo_out.we;
      core_rvalid_o <= core_rd_pend;
      if (core_rd_pend) begin
        core_rdata_o <= width16 ? ram_rdata_i : {8'h00, ram_rdata_i[7:0]};
      end
    end
  end

  // Host memory cycle sequencing
  always_comb begin
    next_hstate = hstate;
    unique case (hstate)
      ISB_H_IDLE: if (mem_sel) next_hstate = ISB_H_WAIT;
      ISB_H_WAIT: begin
        if (!mem_sel) next_hstate = ISB_H_IDLE; // Host gave up
        else if (host_issue) next_hstate = ISB_H_DATA;
      end
      ISB_H_DATA: next_hstate = ISB_H_HOLD;
      ISB_H_HOLD: if (isa_memr_n_i && isa_memw_n_i) next_hstate = ISB_H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hstate <= ISB_H_IDLE;
    end else if (ce_i) begin
      hstate <= next_hstate;
    end
  end

  // Hold the host off until its access has been served
  assign isa_chrdy_o    = 1'b0;
  assign isa_chrdy_oe_o = (hstate == ISB_H_IDLE && mem_sel) ||
                          hstate == ISB_H_WAIT || hstate == ISB_H_DATA;

  // Strobe edge trackers so one I/O cycle acts once
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      iow_seen <= 1'b0;
      ior_seen <= 1'b0;
    end else if (ce_i) begin
      iow_seen <= !isa_iow_n_i;
      ior_seen <= !isa_ior_n_i;
    end
  end

  // Shared-memory address register, written by the host over I/O
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      smem_addr  <= '0;
      smem_valid <= 1'b0;
    end else if (ce_i) begin
      if (!isa_iow_n_i && !iow_seen && io_hit && mem_mode &&
          io_off == `ISB_IO_SMEM_ADDR) begin
        smem_addr  <= isa_sd_i[7:0];
        smem_valid <= 1'b1; // Opens the buffer window
      end
    end
  end

  // I/O read values; width detect LSB shows 16-bit mode
  always_comb begin
    io_rd_val = 8'h00;
    if (io_off == `ISB_IO_SMEM_ADDR) io_rd_val = smem_addr;
    else if (io_off == `ISB_IO_WIDTH_DET) io_rd_val = {7'h00, width16};
  end

  // Host data bus: I/O register reads and captured buffer reads
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      isa_sd_o <= '0;
    end else if (ce_i) begin
      if (!isa_ior_n_i && !ior_seen && io_hit) begin
        isa_sd_o <= {8'h00, io_rd_val};
      end else if (hstate == ISB_H_DATA) begin
        isa_sd_o <= width16 ? ram_rdata_i : {8'h00, ram_rdata_i[7:0]};
      end
    end
  end

  // Drive only during a decoded read, after data is ready
  assign isa_sd_oe_o = (!isa_ior_n_i && ior_seen && io_hit) ||
                       (hstate == ISB_H_HOLD && !isa_memr_n_i);

  // Wishbone: ack one cycle after request, writes land on the ack edge
  assign wb_req = wb_cyc_i && wb_stb_i;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= wb_req && !wb_ack_o;
    end
  end

  // Configuration writes; byte lanes honoured
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      io_base <= `ISB_IO_BASE_RST;
      mode    <= isb_mode_t'(`ISB_MODE_RST);
    end else if (ce_i && wb_req && wb_we_i && wb_ack_o) begin
      if (wb_adr_i == `ISB_WB_CFG_A) begin
        if (wb_sel_i[0]) io_base[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) io_base[9:8] <= wb_dat_i[9:8];
      end
      if (wb_adr_i == `ISB_WB_MODE && wb_sel_i[0]) begin
        mode <= isb_mode_t'(wb_dat_i[1:0]);
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    wb_rd_val = 32'h0000_0000;
    unique case (wb_adr_i)
      `ISB_WB_CFG_A:  wb_rd_val = {22'h00_0000, io_base};
      `ISB_WB_MODE:   wb_rd_val = {30'h0000_0000, mode};
      `ISB_WB_STATUS: wb_rd_val = {16'h0000, smem_addr, 4'h0,
                                   isa_chrdy_oe_o, fifo_valid,
                                   smem_valid, width16};
      default:        wb_rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (ce_i && wb_req && !wb_ack_o) begin
      wb_dat_o <= wb_rd_val;
    end
  end
endmodule // isb_top

// ==== isb_checker.sv ====
module isb_checker
  import isb_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic data_width_select_i,
  input  wire logic wb_cyc_i,
  input  wire logic wb_stb_i,
  input  wire logic wb_ack_o,
  input  wire logic isa_memr_n_i,
  input  wire logic isa_memw_n_i,
  input  wire logic isa_ior_n_i,
  input  wire logic isa_sd_oe_o,
  input  wire logic isa_chrdy_o,
  input  wire logic isa_chrdy_oe_o,
  input  wire logic core_valid_i,
  input  wire logic core_ready_o,
  input  wire logic ram_cs_lo_o,
  input  wire logic ram_cs_hi_o
);
  logic smp;
  logic w16;

  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // Own copy of the strap, taken once so a later pin change is ignored here too
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      smp <= 1'b0;
      w16 <= 1'b0;
    end else if (!smp) begin
      smp <= 1'b1;
      w16 <= data_width_select_i;
    end
  end

  a_chrdy_low: assert property (isa_chrdy_o == 1'b0)
    else $error("channel ready driven high");
  a_idle_no_wait: assert property (isa_memr_n_i && isa_memw_n_i |-> !isa_chrdy_oe_o)
    else $error("wait asserted with no memory cycle");
  a_hold_min: assert property ($fell(isa_memr_n_i) && isa_chrdy_oe_o |-> isa_chrdy_oe_o[*3])
    else $error("host read wait too short");
  a_hold_bound: assert property (($fell(isa_memr_n_i) || $fell(isa_memw_n_i)) && isa_chrdy_oe_o
    |-> ##[3:64] !isa_chrdy_oe_o)
    else $error("host wait never ends");
  a_drive_read: assert property (isa_sd_oe_o |-> !isa_memr_n_i || !isa_ior_n_i)
    else $error("data driven outside a read");
  a_core_served: assert property (core_valid_i && core_ready_o |-> ##[1:16] ram_cs_lo_o)
    else $error("core request not served");
  a_byte_lane: assert property (smp && !w16 |-> !ram_cs_hi_o)
    else $error("upper RAM used in narrow mode");
  a_word_lanes: assert property (w16 && ram_cs_lo_o |-> ram_cs_hi_o)
    else $error("upper RAM missing in wide mode");
  a_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register access not answered");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  c_host_wait: cover property (!isa_memr_n_i && isa_chrdy_oe_o ##1 !isa_chrdy_oe_o);
  c_wide: cover property (w16 && ram_cs_hi_o);
  c_narrow: cover property (smp && !w16 && ram_cs_lo_o);
endmodule // isb_checker

// ==== isb_isa_host.sv ====
module isb_isa_host
  import isb_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic [15:0] sd_o_i,
  input  wire logic        sd_oe_i,
  input  wire logic        chrdy_oe_i,
  output logic [19:0]      sa_o,
  output logic             memr_n_o,
  output logic             memw_n_o,
  output logic             ior_n_o,
  output logic             iow_n_o,
  output logic [15:0]      sd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] drv;
  logic        drv_en;

  // Released lines show the inverse of the last level so stale data never matches
  always_comb sd_o = drv_en ? drv : (sd_oe_i ? sd_o_i : ~drv);

  initial begin
    sa_o = '0;
    memr_n_o = 1'b1;
    memw_n_o = 1'b1;
    ior_n_o = 1'b1;
    iow_n_o = 1'b1;
    drv = '0;
    drv_en = 1'b0;
  end

  // One host cycle; memory cycles stay low while the card pulls ready low
  task automatic cyc(input logic mem, input logic wr, input logic [19:0] a,
                     input logic [15:0] d, output logic [15:0] q, output logic oe,
                     output int w);
    @(posedge core_clk_i);
    sa_o <= a;
    drv <= d;
    drv_en <= wr;
    memr_n_o <= !(mem && !wr);
    memw_n_o <= !(mem && wr);
    ior_n_o <= !(!mem && !wr);
    iow_n_o <= !(!mem && wr);
    @(posedge core_clk_i);
    w = 0;
    // No local limit: a wait that never ends is caught by the bench watchdog
    while (chrdy_oe_i === 1'b1) begin
      @(posedge core_clk_i);
      w++;
    end
    if (!mem) repeat (2) @(posedge core_clk_i);
    q = sd_o_i;
    oe = sd_oe_i;
    memr_n_o <= 1'b1;
    memw_n_o <= 1'b1;
    ior_n_o <= 1'b1;
    iow_n_o <= 1'b1;
    drv_en <= 1'b0;
  endtask
endmodule // isb_isa_host

// ==== testbench.sv ====
module testbench
  import isb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic          core_clk_i, rst_i, ce_i, data_width_select_i;
  logic          wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, oe;
  logic [7:0]    wb_adr_i;
  logic [3:0]    wb_sel_i;
  logic [31:0]   wb_dat_i, wb_dat_o, q;
  logic [19:0]   isa_sa_i;
  logic          isa_memr_n_i, isa_memw_n_i, isa_ior_n_i, isa_iow_n_i;
  logic [15:0]   isa_sd_i, isa_sd_o, h, core_rdata_o, ram_wdata_o, ram_rdata_i;
  logic          isa_sd_oe_o, isa_chrdy_o, isa_chrdy_oe_o;
  logic          core_valid_i, core_ready_o, core_rvalid_o;
  isb_core_req_t core_req_i;
  logic [14:0]   ram_addr_o;
  logic          ram_we_o, ram_cs_lo_o, ram_cs_hi_o;
  logic [15:0]   ram [0:32767];
  int            fails, n_compared, w;

  isb_top dut (.core_clk_i, .rst_i, .ce_i, .data_width_select_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .isa_sa_i,
    .isa_memr_n_i, .isa_memw_n_i, .isa_ior_n_i, .isa_iow_n_i, .isa_sd_i, .isa_sd_o,
    .isa_sd_oe_o, .isa_chrdy_o, .isa_chrdy_oe_o, .core_valid_i, .core_req_i, .core_ready_o,
    .core_rdata_o, .core_rvalid_o, .ram_addr_o, .ram_we_o, .ram_cs_lo_o, .ram_cs_hi_o,
    .ram_wdata_o, .ram_rdata_i);
  isb_isa_host host (.core_clk_i, .sd_o_i(isa_sd_o), .sd_oe_i(isa_sd_oe_o),
    .chrdy_oe_i(isa_chrdy_oe_o), .sa_o(isa_sa_i), .memr_n_o(isa_memr_n_i),
    .memw_n_o(isa_memw_n_i), .ior_n_o(isa_ior_n_i), .iow_n_o(isa_iow_n_i), .sd_o(isa_sd_i));

  // Asynchronous RAM; deselected it shows inverted data
  assign ram_rdata_i = (ram_cs_lo_o | ram_cs_hi_o) ? ram[ram_addr_o] : ~ram[ram_addr_o];
  always @(posedge core_clk_i) begin
    if (ram_we_o && ram_cs_lo_o) ram[ram_addr_o][7:0] <= ram_wdata_o[7:0];
    if (ram_we_o && ram_cs_hi_o) ram[ram_addr_o][15:8] <= ram_wdata_o[15:8];
  end

  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      $display("Error at %0t: register access never acknowledged", $time);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic reset_dut();
    rst_i <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask

  // Back-to-back core writes, valid held across entries
  task automatic core_wr4();
    for (int i = 0; i < 4; i++) begin
      core_valid_i <= 1'b1;
      core_req_i <= '{1'b1, 16'h0100 + 16'(2 * i), 16'ha000 + 16'(i)};
      do @(posedge core_clk_i); while (core_ready_o !== 1'b1);
    end
    core_valid_i <= 1'b0;
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end

  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    data_width_select_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h3;
    wb_dat_i = 32'h0;
    core_valid_i = 1'b0;
    core_req_i = '0;
    fails = 0;
    n_compared = 0;
    reset_dut();
    data_width_select_i <= 1'b0; // Late strap change must not count
    wb(0, 8'h00, 0); chk(q, 32'h300);
    wb(0, 8'h04, 0); chk(q, 32'h0);
    wb(0, 8'h08, 0); chk(q & 32'h1, 32'h1);
    wb(0, 8'h0c, 0); chk(q, 32'h0);
    host.cyc(0, 0, 20'h00301, 0, h, oe, w); chk(32'({oe, h[7:0]}), 32'h101);
    host.cyc(1, 0, 20'hd0004, 0, h, oe, w); chk(32'({w != 0, oe}), 32'h0);
    $display("test reset done");
    host.cyc(0, 1, 20'h00300, 16'h00d0, h, oe, w);
    host.cyc(0, 0, 20'h00300, 0, h, oe, w); chk(32'(h[7:0]), 32'hd0);
    wb(0, 8'h08, 0); chk(q, 32'hd003);
    ram[2] = 16'hbeef;
    host.cyc(1, 0, 20'hd0004, 0, h, oe, w); chk(32'({oe, h}), 32'h1beef);
    host.cyc(1, 1, 20'hd0006, 16'h1234, h, oe, w); chk(32'(ram[3]), 32'h1234);
    wb(1, 8'h00, 32'h280);
    host.cyc(0, 0, 20'h00281, 0, h, oe, w); chk(32'({oe, h[7:0]}), 32'h101);
    host.cyc(0, 0, 20'h00301, 0, h, oe, w); chk(32'(oe), 32'h0);
    // Clock enable low: an I/O write must leave the address register alone
    ce_i <= 1'b0;
    host.cyc(0, 1, 20'h00280, 16'h0011, h, oe, w);
    ce_i <= 1'b1;
    host.cyc(0, 0, 20'h00280, 0, h, oe, w); chk(32'(h[7:0]), 32'hd0);
    $display("test shared window done");
    for (int m = 0; m < 4; m++) begin
      wb(1, 8'h04, 32'(m));
      host.cyc(1, 0, 20'hd0004, 0, h, oe, w); chk(32'(w != 0), 32'(m < 2));
    end
    wb(1, 8'h04, 32'h0);
    $display("test modes done");
    fork
      core_wr4();
      begin
        @(posedge core_clk_i);
        host.cyc(1, 0, 20'hd0100, 0, h, oe, w);
      end
    join
    chk(32'(h), 32'ha000);
    chk(32'(w > 3), 32'h1);
    @(posedge core_clk_i);
    core_valid_i <= 1'b1;
    core_req_i <= '{1'b0, 16'h0102, 16'h0};
    do @(posedge core_clk_i); while (core_ready_o !== 1'b1);
    core_valid_i <= 1'b0;
    w = 0;
    while (core_rvalid_o !== 1'b1 && w < 20) begin
      @(posedge core_clk_i);
      w++;
    end
    chk(32'(w < 20), 32'h1);
    chk(32'(core_rdata_o), 32'ha001);
    $display("test priority done");
    reset_dut();
    wb(0, 8'h08, 0); chk(q & 32'h1, 32'h0);
    host.cyc(1, 0, 20'hd0005, 0, h, oe, w); chk(32'({w != 0, oe}), 32'h0);
    host.cyc(0, 1, 20'h00300, 16'h00d0, h, oe, w);
    ram[5] = 16'h5a3c;
    host.cyc(1, 0, 20'hd0005, 0, h, oe, w); chk(32'(h[7:0]), 32'h3c);
    host.cyc(1, 1, 20'hd0007, 16'h0077, h, oe, w); chk(32'(ram[7][7:0]), 32'h77);
    host.cyc(0, 0, 20'h00301, 0, h, oe, w); chk(32'({oe, h[7:0]}), 32'h100);
    $display("test narrow done");
    close_out();
  end
endmodule // testbench

bind isb_top isb_checker u_chk (.core_clk_i, .rst_i, .data_width_select_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .isa_memr_n_i, .isa_memw_n_i, .isa_ior_n_i, .isa_sd_oe_o,
  .isa_chrdy_o, .isa_chrdy_oe_o, .core_valid_i, .core_ready_o, .ram_cs_lo_o, .ram_cs_hi_o);
